// ===== terminal_channel_job_sequencer.sv
// Descriptor-driven job sequencer for a terminal data channel.
`include "tcj_regs.svh"
module terminal_channel_job_sequencer (
	input wire logic REF_CLK_I, // System clock.
	input wire logic RST_I, // Asynchronous reset, active high.
	input wire logic PSEL_I, // APB select.
	input wire logic PENABLE_I, // APB enable.
	input wire logic PWRITE_I, // APB direction.
	input wire logic [11:0] PADDR_I, // APB byte address.
	input wire logic [31:0] PWDATA_I, // APB write data.
	output logic PREADY_O, // APB ready.
	output logic [31:0] PRDATA_O, // APB read data.
	output logic PSLVERR_O, // APB error.
	output tcj_pkg::mem_req_type MEM_REQ_O, // Memory request.
	input wire logic MEM_ACK_I, // Memory acknowledge.
	input wire logic [31:0] MEM_RDATA_I, // Memory read data.
	output tcj_pkg::link_word_type LINK_TX_O, // Word to selector unit.
	output logic LINK_TX_VALID_O, // Outbound word valid.
	input wire logic LINK_TX_READY_I, // Selector unit takes word.
	input tcj_pkg::link_word_type LINK_RX_I, // Word from selector unit.
	input wire logic LINK_RX_VALID_I, // Inbound word valid.
	output logic LINK_RX_READY_O, // Sequencer takes word.
	output logic [7:0] PORT_SEL_O // Port of the current job.
);
	tcj_pkg::seq_state_type q, d;
	logic acc, ack, rxa;

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	// even parity
	function automatic logic par(input logic c, input logic [31:0] w);
		return ^{c, w};
	endfunction : par

	function automatic logic [23:0] wadr(input logic [23:0] b, input logic [2:0] i);
		return {b[23:3], i};
	endfunction : wadr

	function automatic tcj_pkg::mem_req_type issue(input logic we, input logic [23:0] a,
		input logic [31:0] w);
		return {1'b1, we, a, w};
	endfunction : issue

	function automatic logic is_job(input tcj_pkg::fsm_type s);
		return s inside {tcj_pkg::S_DGO, tcj_pkg::S_DRD, tcj_pkg::S_SEND, tcj_pkg::S_DRX,
			tcj_pkg::S_DWR, tcj_pkg::S_SCW2, tcj_pkg::S_WAIT3, tcj_pkg::S_RELNK,
			tcj_pkg::S_REREAD, tcj_pkg::S_WB7, tcj_pkg::S_WB5};
	endfunction : is_job

	function automatic tcj_pkg::fsm_type post(input tcj_pkg::seq_state_type s);
		logic n2, n3;
		n2 = !s.o2 && !s.c2d;
		n3 = !s.o3 && !s.c3d;
		if (s.dir) begin
			post = n3 ? tcj_pkg::S_WAIT3 : (n2 ? tcj_pkg::S_SCW2 : tcj_pkg::S_RELNK);
		end else begin
			post = n2 ? tcj_pkg::S_SCW2 : (n3 ? tcj_pkg::S_WAIT3 : tcj_pkg::S_RELNK);
		end
	endfunction : post

	// Ends the job early; the status write-back still follows.
	function automatic tcj_pkg::seq_state_type kill(input tcj_pkg::seq_state_type s);
		s.st = tcj_pkg::S_WB7;
		s.txv = 1'b0;
		return s;
	endfunction : kill

	assign acc = PSEL_I & PENABLE_I;
	assign ack = q.mem.req & MEM_ACK_I;
	assign rxa = q.rxr & LINK_RX_VALID_I;

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		d = q;
		d.rdy = 1'b0;
		d.err = 1'b0;
		if (acc && !q.rdy) begin
			d.rdy = 1'b1;
			d.rdat = 32'h00000000;
			if (PADDR_I == `CMD_OFF) begin
				d.rdat = {27'h0000000, q.cmd};
			end else if (PADDR_I == `STAT_OFF) begin
				d.rdat = {q.cnt, q.port, 5'h00, q.saved_v, q.hi, q.st != tcj_pkg::S_IDLE};
			end else begin
				d.err = 1'b1;
			end
		end
		case (q.st)
			tcj_pkg::S_IDLE: begin
				if (q.cmd[`B_HIGH]) begin
					d.hi = 1'b1;
					d.base = `HIGH_HDR;
					d.st = tcj_pkg::S_HDR;
				end else if (q.cmd[`B_LOW]) begin
					d.hi = 1'b0;
					d.base = `LOW_HDR;
					d.st = tcj_pkg::S_HDR;
				end
			end
			tcj_pkg::S_HDR: begin
				if (!q.mem.req) begin
					d.mem = issue(1'b0, q.base, 32'h00000000);
				end else if (ack) begin
					d.mem.req = 1'b0;
					d.base = MEM_RDATA_I[23:0];
					d.idx = `W_LINK;
					d.st = tcj_pkg::S_FETCH;
				end
			end
			tcj_pkg::S_FETCH: begin
				if (!q.mem.req) begin
					d.mem = issue(1'b0, wadr(q.base, q.idx), 32'h00000000);
				end else if (ack) begin
					d.mem.req = 1'b0;
					d.idx = (q.idx == `W_LINK) ? `W_DIR : (q.idx == `W_CMD) ? `W_MSG : q.idx + 3'h1;
					case (q.idx)
						`W_LINK: begin
							if (!MEM_RDATA_I[`CA_BIT]) begin
								d.idx = `W_LINK;
								d.st = tcj_pkg::S_IDLE;
								d.cmd[q.hi ? `B_HIGH : `B_LOW] = 1'b0;
								if (q.hi && q.cmd[`B_LOW]) begin
									d.hi = 1'b0;
									d.saved_v = 1'b0;
									d.base = q.saved_v ? q.saved : `LOW_HDR;
									d.st = q.saved_v ? tcj_pkg::S_FETCH : tcj_pkg::S_HDR;
								end
							end else begin
								d.link = MEM_RDATA_I[23:0];
							end
						end
						`W_DIR: begin
							d.dir = MEM_RDATA_I[`DIR_BIT];
						end
						`W_PORT: begin
							d.port = MEM_RDATA_I[31:24];
							d.addr = MEM_RDATA_I[23:0];
						end
						`W_CMD: begin
							d.o1 = MEM_RDATA_I[`OPT1_BIT];
							d.o2 = MEM_RDATA_I[`OPT2_BIT];
							d.o3 = MEM_RDATA_I[`OPT3_BIT];
							d.cnt = MEM_RDATA_I[15:0];
						end
						default: begin
							d.msg1 = MEM_RDATA_I[31:16];
							d.msg2 = MEM_RDATA_I[15:0];
							{d.mism, d.to, d.pe, d.w7, d.c2d, d.c3d, d.abj, d.stl} = 8'h00;
							d.sstat = 16'h0000;
							d.cerr = 16'h0000;
							d.st = tcj_pkg::S_DGO;
							if (!q.o1) begin
								d.tx = {1'b1, par(1'b1, {16'h0000, MEM_RDATA_I[31:16]}),
									16'h0000, MEM_RDATA_I[31:16]};
								d.txv = 1'b1;
								d.kind = tcj_pkg::K_CW1;
								d.st = tcj_pkg::S_SEND;
							end
						end
					endcase
				end
			end
			tcj_pkg::S_DGO: begin
				if (q.cnt == 16'h0000) begin
					d.st = post(q);
				end else begin
					d.st = q.dir ? tcj_pkg::S_DRX : tcj_pkg::S_DRD;
				end
			end
			tcj_pkg::S_DRD: begin
				if (!q.mem.req) begin
					d.mem = issue(1'b0, q.addr, 32'h00000000);
				end else if (ack) begin
					d.mem.req = 1'b0;
					d.tx = {1'b0, par(1'b0, MEM_RDATA_I), MEM_RDATA_I};
					d.txv = 1'b1;
					d.kind = tcj_pkg::K_DATA;
					d.st = tcj_pkg::S_SEND;
				end
			end
			tcj_pkg::S_SEND: begin
				if (q.txv && LINK_TX_READY_I) begin
					d.txv = 1'b0;
					d.st = tcj_pkg::S_DGO;
					if (q.kind == tcj_pkg::K_DATA) begin
						d.cnt = q.cnt - 16'h0001;
						d.addr = q.addr + 24'h000001;
					end else if (q.kind == tcj_pkg::K_CW2) begin
						d.c2d = 1'b1;
						d.st = post(d);
					end
				end
			end
			tcj_pkg::S_DWR: begin
				if (!q.mem.req) begin
					d.mem = issue(1'b1, q.addr, q.tx.data);
				end else if (ack) begin
					d.mem.req = 1'b0;
					d.cnt = q.cnt - 16'h0001;
					d.addr = q.addr + 24'h000001;
					d.st = tcj_pkg::S_DGO;
				end
			end
			tcj_pkg::S_SCW2: begin
				d.tx = {1'b1, par(1'b1, {1'b0, q.mism, q.to, q.pe, 12'h000, q.msg2}),
					1'b0, q.mism, q.to, q.pe, 12'h000, q.msg2};
				d.txv = 1'b1;
				d.kind = tcj_pkg::K_CW2;
				d.st = tcj_pkg::S_SEND;
			end
			tcj_pkg::S_DRX, tcj_pkg::S_WAIT3: begin
			end
			tcj_pkg::S_RELNK: begin
				if (q.cmd[`B_ROK]) begin
					d.stl = 1'b1;
				end else begin
					d.stl = 1'b0;
					d.st = q.stl ? tcj_pkg::S_REREAD : tcj_pkg::S_WB7;
				end
			end
			tcj_pkg::S_REREAD: begin
				if (!q.mem.req) begin
					d.mem = issue(1'b0, wadr(q.base, `W_LINK), 32'h00000000);
				end else if (ack) begin
					d.mem.req = 1'b0;
					d.link = MEM_RDATA_I[23:0];
					d.st = tcj_pkg::S_WB7;
				end
			end
			tcj_pkg::S_WB7: begin
				if (!q.w7) begin
					d.st = tcj_pkg::S_WB5;
				end else if (!q.mem.req) begin
					d.mem = issue(1'b1, wadr(q.base, `W_ERR), {q.cerr, q.msg3});
				end else if (ack) begin
					d.mem.req = 1'b0;
					d.st = tcj_pkg::S_WB5;
				end
			end
			tcj_pkg::S_WB5: begin
				if (!q.mem.req) begin
					d.mem = issue(1'b1, wadr(q.base, `W_STAT),
						{1'b1, q.mism, q.to, q.pe, 12'h000, q.sstat});
				end else if (ack) begin
					d.mem.req = 1'b0;
					d.st = tcj_pkg::S_NEXT;
				end
			end
			tcj_pkg::S_NEXT: begin
				d.idx = `W_LINK;
				d.st = tcj_pkg::S_FETCH;
				d.base = q.link;
				if (q.abj) begin
					d.abj = 1'b0;
					d.hi = q.cmd[`B_HIGH];
					d.base = q.cmd[`B_HIGH] ? `HIGH_HDR : `LOW_HDR;
					d.st = tcj_pkg::S_HDR;
				end else if (!q.hi && q.cmd[`B_HIGH]) begin
					d.saved = q.link;
					d.saved_v = 1'b1;
					d.hi = 1'b1;
					d.base = `HIGH_HDR;
					d.st = tcj_pkg::S_HDR;
				end
			end
			default: begin
				d.st = tcj_pkg::S_IDLE;
			end
		endcase
		if (q.st inside {tcj_pkg::S_SEND, tcj_pkg::S_DRX, tcj_pkg::S_WAIT3}) begin
			d.tmo = q.tmo + 12'h001;
			if (q.tmo == 12'(`TO_CYC)) begin
				d.to = 1'b1;
				d = kill(d);
			end
		end else begin
			d.tmo = 12'h000;
		end
		if (rxa) begin
			if (par(LINK_RX_I.ctrl, LINK_RX_I.data) != LINK_RX_I.par) begin
				d.pe = 1'b1;
				d = kill(d);
			end else if (LINK_RX_I.ctrl) begin
				d.msg3 = LINK_RX_I.data[15:0];
				d.sstat = LINK_RX_I.data[31:16];
				d.w7 = 1'b1;
				if (q.cnt != 16'h0000) begin
					d.mism = 1'b1;
					d.cerr = q.cnt;
				end
				if (q.st == tcj_pkg::S_WAIT3 && q.cnt == 16'h0000) begin
					d.c3d = 1'b1;
					d.st = post(d);
				end else begin
					d = kill(d);
				end
			end else if (q.st == tcj_pkg::S_DRX && q.cnt != 16'h0000) begin
				d.tx.data = LINK_RX_I.data;
				d.st = tcj_pkg::S_DWR;
			end else begin
				d.mism = 1'b1;
				d = kill(d);
			end
		end
		if (q.cmd[`B_ABORT] && !q.mem.req) begin
			d.cmd[`B_ABORT] = 1'b0;
			// Cancels a request issued in this cycle, so no stale answer is taken later.
			d.mem.req = 1'b0;
			if (!q.cmd[`B_LOW] && !q.cmd[`B_HIGH]) begin
				d.st = tcj_pkg::S_IDLE;
				d.txv = 1'b0;
				d.saved_v = 1'b0;
			end else if (is_job(q.st)) begin
				d = kill(d);
				d.abj = 1'b1;
			end else if (q.st != tcj_pkg::S_IDLE) begin
				d.hi = q.cmd[`B_HIGH];
				d.base = q.cmd[`B_HIGH] ? `HIGH_HDR : `LOW_HDR;
				d.st = tcj_pkg::S_HDR;
			end
		end
		if (acc && q.rdy && PWRITE_I && PADDR_I == `CMD_OFF) begin
			d.cmd[`B_ABORT:`B_LOW] = PWDATA_I[`B_ABORT:`B_LOW];
			d.cmd[`B_RREQ] = PWDATA_I[`B_RREQ];
			if (!PWDATA_I[`B_ROK]) begin
				d.cmd[`B_ROK] = 1'b0;
			end
		end
		if (d.cmd[`B_RREQ] && is_job(q.st)) begin
			d.cmd[`B_ROK] = 1'b1;
		end
		// Not ready in the cycle after a take, so a waiting word is taken in its own slot.
		d.rxr = !rxa && (d.st inside {tcj_pkg::S_DRX, tcj_pkg::S_WAIT3, tcj_pkg::S_SEND,
			tcj_pkg::S_SCW2});
	end

	always_ff @(posedge REF_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			q <= '0;
			q.st <= tcj_pkg::S_IDLE;
			q.cmd <= `CMD_RST;
		end else begin
			q <= d;
		end
	end

	assign PREADY_O = q.rdy;
	assign PRDATA_O = q.rdat;
	assign PSLVERR_O = q.err;
	assign MEM_REQ_O = q.mem;
	assign LINK_TX_O = q.tx;
	assign LINK_TX_VALID_O = q.txv;
	assign LINK_RX_READY_O = q.rxr;
	assign PORT_SEL_O = q.port;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	logic fa, rxc;
	assign fa = ack && q.st == tcj_pkg::S_FETCH;
	assign rxc = rxa && LINK_RX_I.ctrl && par(LINK_RX_I.ctrl, LINK_RX_I.data) == LINK_RX_I.par;

	default clocking cb @(posedge REF_CLK_I);
	endclocking
	default disable iff (RST_I);

	sequence s_rok_drop;
		q.st == tcj_pkg::S_RELNK && q.stl && !q.cmd[`B_ROK];
	endsequence
	sequence s_reread;
		q.st == tcj_pkg::S_REREAD ##[1:300] q.st == tcj_pkg::S_WB7;
	endsequence

	a_link_take: assert property (fa && q.idx == `W_LINK && MEM_RDATA_I[`CA_BIT] |=>
		q.link == $past(MEM_RDATA_I[23:0])) else $error("link address not latched");
	a_port_take: assert property (fa && q.idx == `W_PORT |=>
		PORT_SEL_O == $past(MEM_RDATA_I[31:24])) else $error("port not latched");
	a_dir_take: assert property (fa && q.idx == `W_DIR |=>
		q.dir == $past(MEM_RDATA_I[`DIR_BIT])) else $error("direction not latched");
	a_count_dec: assert property (q.st == tcj_pkg::S_SEND && q.txv && LINK_TX_READY_I &&
		q.kind == tcj_pkg::K_DATA |=> q.cnt == $past(q.cnt) - 16'h0001)
		else $error("count not decremented");
	a_done_write: assert property (q.st == tcj_pkg::S_WB5 && MEM_REQ_O.req |->
		MEM_REQ_O.we && MEM_REQ_O.wdata[31] && MEM_REQ_O.wdata[28] == q.pe)
		else $error("status word lacks done or parity flag");
	a_mism_count: assert property (rxc && q.cnt != 16'h0000 |=>
		q.mism && q.cerr == $past(q.cnt)) else $error("mismatch not recorded");
	a_status_copy: assert property (rxc |=>
		q.sstat == $past(LINK_RX_I.data[31:16])) else $error("unit status not copied");
	a_cw1_msg: assert property (LINK_TX_VALID_O && q.kind == tcj_pkg::K_CW1 |->
		LINK_TX_O.ctrl && LINK_TX_O.data[15:0] == q.msg1) else $error("bad first control word");
	a_relink_hold: assert property (q.st == tcj_pkg::S_RELNK && q.cmd[`B_ROK] |=>
		q.st == tcj_pkg::S_RELNK) else $error("stall left while granted");
	a_relink_reread: assert property (s_rok_drop |=> s_reread)
		else $error("link not reread after grant cleared");
endmodule : terminal_channel_job_sequencer

// ===== tcj_regs.svh
// Register offsets, field positions, reset values and timing of the job sequencer.
`ifndef TCJ_REGS_SVH
`define TCJ_REGS_SVH
`define CMD_OFF 12'h000
`define STAT_OFF 12'h004
`define CMD_RST 5'h00
`define B_LOW 0
`define B_HIGH 1
`define B_ABORT 2
`define B_RREQ 3
`define B_ROK 4
`define LOW_HDR 24'h000100
`define HIGH_HDR 24'h000108
`define W_LINK 3'h0
`define W_DIR 3'h2
`define W_PORT 3'h3
`define W_CMD 3'h4
`define W_STAT 3'h5
`define W_MSG 3'h6
`define W_ERR 3'h7
`define CA_BIT 31
`define DIR_BIT 16
`define OPT1_BIT 31
`define OPT2_BIT 30
`define OPT3_BIT 29
`define CLK_NS 20
`define TO_NS 20000
`define TO_CYC ((`TO_NS + `CLK_NS - 1) / `CLK_NS)
`endif

// ===== tcj_pkg.sv
// Types shared by the terminal channel job sequencer.
package tcj_pkg;
	typedef enum logic [14:0] {
		S_IDLE = 15'h0001,
		S_HDR = 15'h0002,
		S_FETCH = 15'h0004,
		S_DGO = 15'h0008,
		S_DRD = 15'h0010,
		S_SEND = 15'h0020,
		S_DRX = 15'h0040,
		S_DWR = 15'h0080,
		S_SCW2 = 15'h0100,
		S_WAIT3 = 15'h0200,
		S_RELNK = 15'h0400,
		S_REREAD = 15'h0800,
		S_WB7 = 15'h1000,
		S_WB5 = 15'h2000,
		S_NEXT = 15'h4000
	} fsm_type;
	typedef enum logic [1:0] {
		K_CW1 = 2'h0,
		K_DATA = 2'h1,
		K_CW2 = 2'h2
	} kind_type;
	typedef struct packed {
		logic ctrl;
		logic par;
		logic [31:0] data;
	} link_word_type;
	typedef struct packed {
		logic req;
		logic we;
		logic [23:0] addr;
		logic [31:0] wdata;
	} mem_req_type;
	typedef struct packed {
		fsm_type st;
		kind_type kind;
		logic [2:0] idx;
		logic [23:0] base, link, addr, saved;
		logic saved_v, hi, dir, o1, o2, o3, mism, to, pe, w7, c2d, c3d, abj, stl;
		logic txv, rxr, rdy, err;
		logic [7:0] port;
		logic [15:0] cnt, msg1, msg2, msg3, sstat, cerr;
		logic [4:0] cmd;
		logic [11:0] tmo;
		logic [31:0] rdat;
		link_word_type tx;
		mem_req_type mem;
	} seq_state_type;
endpackage : tcj_pkg

// ===== selector_unit_model.sv
// Behavioural selector unit that trades link words with the job sequencer.
module selector_unit_model (
	input wire logic clk_i, // System clock.
	input wire logic rst_i, // Reset, active high.
	input tcj_pkg::link_word_type tx_i, // Word from the sequencer.
	input wire logic tx_valid_i, // Outbound word valid.
	output logic tx_ready_o, // Word taken at this edge.
	output tcj_pkg::link_word_type rx_o, // Word to the sequencer.
	output logic rx_valid_o, // Inbound word valid.
	input wire logic rx_ready_i // Sequencer takes the word.
);
	timeunit 1ns;
	timeprecision 1ns;
	tcj_pkg::link_word_type tx_q[$];
	tcj_pkg::link_word_type rx_q[$];
	initial begin
		tx_ready_o = 1'b0;
		rx_valid_o = 1'b0;
		rx_o = '0;
	end
	// Whole words move with their type and parity bits.
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			tx_ready_o <= 1'b0;
			rx_valid_o <= 1'b0;
			rx_o <= '0;
		end else begin
			if (tx_valid_i && tx_ready_o) begin
				tx_q.push_back(tx_i);
			end
			tx_ready_o <= ($urandom_range(2) != 0);
			if (!rx_valid_o || rx_ready_i) begin
				if (rx_q.size() > 0 && $urandom_range(1) == 0) begin
					rx_o <= rx_q.pop_front();
					rx_valid_o <= 1'b1;
				end else begin
					// Released lines invert every cycle, so they alternate between the last word and its inverse.
					rx_o <= ~rx_o;
					rx_valid_o <= 1'b0;
				end
			end
		end
	end
endmodule : selector_unit_model

// ===== testbench.sv
// Self-checking testbench of the terminal channel job sequencer.
`include "tcj_regs.svh"
`define CHECK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin mismatches++; \
	$display("wrong value %s expected %h seen %h", nm, ex, got); end end
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	logic ref_clk, rst, psel, penable, pwrite, pready, pslverr, mem_ack;
	logic tx_valid, tx_ready, rx_valid, rx_ready, e;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, mem_rdata, r;
	logic [7:0] port_sel;
	tcj_pkg::mem_req_type mem_req;
	tcj_pkg::link_word_type link_tx, link_rx;
	logic [31:0] mem [logic [23:0]];
	logic [23:0] wb_q[$];
	int mismatches, check_count;

	terminal_channel_job_sequencer u_dut (.REF_CLK_I(ref_clk), .RST_I(rst), .PSEL_I(psel),
		.PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata),
		.PREADY_O(pready), .PRDATA_O(prdata), .PSLVERR_O(pslverr), .MEM_REQ_O(mem_req),
		.MEM_ACK_I(mem_ack), .MEM_RDATA_I(mem_rdata), .LINK_TX_O(link_tx),
		.LINK_TX_VALID_O(tx_valid), .LINK_TX_READY_I(tx_ready), .LINK_RX_I(link_rx),
		.LINK_RX_VALID_I(rx_valid), .LINK_RX_READY_O(rx_ready), .PORT_SEL_O(port_sel));
	selector_unit_model u_sel (.clk_i(ref_clk), .rst_i(rst), .tx_i(link_tx),
		.tx_valid_i(tx_valid), .tx_ready_o(tx_ready), .rx_o(link_rx), .rx_valid_o(rx_valid),
		.rx_ready_i(rx_ready));

	// ----------------------------------------------------------------
	// Clock and main memory.
	// ----------------------------------------------------------------
	initial begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			mem_ack <= 1'b0;
		end else if (mem_ack) begin
			mem_ack <= 1'b0;
			mem_rdata <= ~mem_rdata;
		end else if (mem_req.req && $urandom_range(2) == 0) begin
			mem_ack <= 1'b1;
			if (mem_req.we) begin
				mem[mem_req.addr] = mem_req.wdata;
				if (mem_req.addr[2:0] == `W_STAT) begin
					wb_q.push_back(mem_req.addr);
				end
			end else begin
				mem_rdata <= mem[mem_req.addr];
			end
		end
	end

	// ----------------------------------------------------------------
	// Helpers.
	// ----------------------------------------------------------------
	function automatic tcj_pkg::link_word_type mk(input logic c, input logic [31:0] d);
		mk = '{ctrl: c, par: ^{c, d}, data: d};
	endfunction : mk
	task automatic report_and_stop();
		if (mismatches == 0 && check_count > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : report_and_stop
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
		int i;
		@(posedge ref_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge ref_clk);
		penable <= 1'b1;
		i = 0;
		do begin
			@(posedge ref_clk);
			i++;
		end while (pready !== 1'b1 && i < 100);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (i >= 100) begin
			mismatches++;
			report_and_stop();
		end
	endtask : apb
	// Start bits fall once each chain is back at its header.
	task automatic wait_idle(input logic [1:0] m);
		for (int i = 0; i < 600; i++) begin
			apb(1'b0, `CMD_OFF, 32'h0);
			if ((r[1:0] & m) == 2'b00) begin
				return;
			end
		end
		mismatches++;
		report_and_stop();
	endtask : wait_idle
	task automatic put_ca(input logic [23:0] h, b, input logic rd, input logic [2:0] opt,
			input logic [15:0] n, input logic [7:0] p, input logic [31:0] msgs);
		// Header word has a clear top bit and points at the first descriptor.
		mem[h] = {8'h00, b};
		// Descriptor word zero has its top bit set and links back to the header.
		mem[b + `W_LINK] = {8'h80, h};
		mem[b + `W_DIR] = {15'h0, rd, 16'h0};
		mem[b + `W_PORT] = {p, b + 24'h000200};
		mem[b + `W_CMD] = {opt, 13'h0, n};
		mem[b + `W_STAT] = 32'h0;
		mem[b + `W_MSG] = msgs;
		mem[b + `W_ERR] = 32'h0;
		mem[b + 24'h000200] = $urandom;
	endtask : put_ca
	task automatic three_cas();
		put_ca(`LOW_HDR, 24'h000280, 1'b0, 3'b111, 16'h1, 8'h32, 32'h0);
		put_ca(`LOW_HDR, 24'h000200, 1'b1, 3'b111, 16'h1, 8'h31, 32'h0);
		mem[24'h000200] = 32'h8000_0280;
		put_ca(`HIGH_HDR, 24'h000300, 1'b0, 3'b111, 16'h1, 8'h33, 32'h0);
		wb_q.delete();
	endtask : three_cas
	task automatic chk_wb(input logic [23:0] a, b, c);
		`CHECK("write-back count", 3, wb_q.size())
		`CHECK("write-back order", {a, b, c}, {wb_q[0], wb_q[1], wb_q[2]})
	endtask : chk_wb
	task automatic run_job(input int kind, input logic rd, input logic [2:0] opt,
			input logic [15:0] n);
		tcj_pkg::link_word_type ex_q[$];
		tcj_pkg::link_word_type rx_l[$];
		logic [31:0] d_q[$];
		logic [31:0] w, m, st, w5, w7;
		logic [7:0] p;
		logic cw;
		int k;
		m = $urandom;
		st = $urandom;
		p = 8'($urandom);
		u_sel.tx_q.delete();
		put_ca(`LOW_HDR, 24'h000200, rd, opt, n, p, m);
		if (!opt[2]) ex_q.push_back(mk(1'b1, {16'h0, m[31:16]}));
		for (int i = 0; i < n; i++) begin
			w = $urandom;
			d_q.push_back(w);
			if (rd) rx_l.push_back(mk(1'b0, w));
			else begin
				mem[24'(32'h400 + i)] = w;
				ex_q.push_back(mk(1'b0, w));
			end
		end
		if (!opt[0]) rx_l.push_back(mk(1'b1, st));
		if (!opt[1]) ex_q.push_back(mk(1'b1, {16'h0, m[15:0]}));
		k = rd ? int'(!opt[2]) : ex_q.size();
		if (kind == 1) rx_l = '{rx_l[0], mk(1'b1, st)};
		if (kind == 2) rx_l[0].par = ~rx_l[0].par;
		if (kind == 3) rx_l.delete();
		apb(1'b1, `CMD_OFF, 32'h1 << `B_LOW);
		for (int i = 0; u_sel.tx_q.size() < k; i++) begin
			@(posedge ref_clk);
			if (i > 5000) begin
				mismatches++;
				report_and_stop();
			end
		end
		if (k > 0) `CHECK("port", p, port_sel)
		foreach (rx_l[i]) u_sel.rx_q.push_back(rx_l[i]);
		wait_idle(2'b01);
		if (kind == 0) begin
			`CHECK("link count", ex_q.size(), u_sel.tx_q.size())
			foreach (ex_q[i]) `CHECK("link word", ex_q[i], u_sel.tx_q[i])
			if (rd) foreach (d_q[i]) `CHECK("memory data", d_q[i], mem[24'(32'h400 + i)])
		end
		cw = (kind == 1) || (kind == 0 && !opt[0]);
		w5 = {1'b1, kind == 1, kind == 3, kind == 2, 12'h0, cw ? st[31:16] : 16'h0};
		w7 = cw ? {(kind == 1) ? n - 16'h1 : 16'h0, st[15:0]} : 32'h0;
		`CHECK("status word", w5, mem[24'h000205])
		`CHECK("count error word", w7, mem[24'h000207])
	endtask : run_job

	// ----------------------------------------------------------------
	// Main sequence.
	// ----------------------------------------------------------------
	initial begin
		mismatches = 0;
		check_count = 0;
		rst = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = '0;
		mem_ack = 1'b0;
		mem_rdata = '0;
		void'($urandom(32'h1688));
		repeat (6) @(posedge ref_clk);
		rst <= 1'b0;
		apb(1'b0, 12'h00C, 32'h0);
		`CHECK("unmapped error", 1'b1, e)
		`CHECK("unmapped data", 32'h0, r)
		run_job(0, 1'b1, 3'b000, 16'h1);
		run_job(0, 1'b0, 3'b000, 16'h1);
		run_job(1, 1'b1, 3'b110, 16'h3);
		run_job(2, 1'b1, 3'b111, 16'h1);
		run_job(3, 1'b1, 3'b111, 16'h1);
		for (int j = 0; j < 10; j++) begin
			run_job(0, 1'($urandom_range(1)), 3'($urandom_range(7)), 16'($urandom_range(4, 1)));
		end
		three_cas();
		apb(1'b1, `CMD_OFF, 32'h1);
		repeat (80) @(posedge ref_clk);
		apb(1'b1, `CMD_OFF, 32'h3);
		u_sel.rx_q.push_back(mk(1'b0, $urandom));
		wait_idle(2'b11);
		chk_wb(24'h000205, 24'h000305, 24'h000285);
		three_cas();
		apb(1'b1, `CMD_OFF, 32'h3);
		wait_idle(2'b11);
		chk_wb(24'h000305, 24'h000205, 24'h000285);
		three_cas();
		put_ca(`LOW_HDR, 24'h000200, 1'b0, 3'b111, 16'h1, 8'h41, 32'h0);
		apb(1'b1, `CMD_OFF, 32'h9);
		for (int i = 0; i < 200 && r[`B_ROK] !== 1'b1; i++) apb(1'b0, `CMD_OFF, 32'h0);
		`CHECK("relink permitted", 1'b1, r[`B_ROK])
		repeat (100) @(posedge ref_clk);
		`CHECK("stalled status", 32'h0, mem[24'h000205])
		// The new job is linked behind the one in progress.
		mem[24'h000200] = 32'h8000_0280;
		// Request is dropped before permission is cleared.
		apb(1'b1, `CMD_OFF, 32'h11);
		apb(1'b1, `CMD_OFF, 32'h1);
		wait_idle(2'b01);
		`CHECK("relinked job status", 32'h8000_0000, mem[24'h000285])
		// Abort with both starts clear stops the channel without a status write.
		put_ca(`LOW_HDR, 24'h000200, 1'b1, 3'b111, 16'h1, 8'h42, 32'h0);
		apb(1'b1, `CMD_OFF, 32'h1);
		repeat (150) @(posedge ref_clk);
		apb(1'b1, `CMD_OFF, 32'h4);
		apb(1'b0, `STAT_OFF, 32'h0);
		`CHECK("busy after abort", 1'b0, r[0])
		apb(1'b0, `CMD_OFF, 32'h0);
		`CHECK("command after abort", 5'h00, r[4:0])
		repeat (20) @(posedge ref_clk);
		`CHECK("aborted status", 32'h0, mem[24'h000205])
		`CHECK("request after abort", 1'b0, mem_req.req)
		report_and_stop();
	end
endmodule : testbench
